// *** core/pscl_loader.sv ***
// Strap capture and register defaults of the transceiver
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pscl_loader (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hardware_reset_pin_n,
  input wire logic [2:0] station_address_straps,
  input wire logic [2:0] mode_straps,
  input wire logic reduced_if_select_strap,
  input wire logic [4:0] frame_address,
  input wire logic frame_valid,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic frame_match,
  output logic [10:0] scrambler_seed,
  output logic shared_pins_oe,
  output logic host_if_rmii,
  output logic core_powered_down,
  output logic carrier_on_transmit,
  output logic repeater_mode,
  output logic core_reconfig
);
  // Pin reset is asynchronous: three stages, change once last two agree
  logic [2:0] rst_sync_r;
  logic pin_rst_r;
  logic [2:0] addr_m1_r, addr_m2_r, addr_m3_r, addr_s2_r;
  logic [2:0] mode_m1_r, mode_m2_r, mode_m3_r, mode_s2_r;
  logic rmii_m1_r, rmii_m2_r, rmii_m3_r, rmii_s2_r;
  pscl_pkg::pscl_state_e state_r, state_nxt;
  logic [2:0] settle_r;
  logic [15:0] ctrl_r, adv_r, modes_r;
  logic crs_tx_r, repeat_r;
  logic [2:0] mode_now;
  logic in_reset, capture, settled;
  logic bus_req, bus_wr, soft_rst_wr, mapped;
  logic [15:0] wdat, rdat;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_sync_r <= 3'h0;
      pin_rst_r <= 1'b1;
    end else begin
      rst_sync_r <= {rst_sync_r[1:0], hardware_reset_pin_n};
      if (rst_sync_r[2] == rst_sync_r[1]) begin
        pin_rst_r <= ~rst_sync_r[2];
      end
    end
  end

  // Straps take three stages; a level counts once the last two agree
  always_ff @(posedge clk) begin
    addr_m1_r <= station_address_straps;
    addr_m2_r <= addr_m1_r;
    addr_m3_r <= addr_m2_r;
    mode_m1_r <= mode_straps;
    mode_m2_r <= mode_m1_r;
    mode_m3_r <= mode_m2_r;
    rmii_m1_r <= reduced_if_select_strap;
    rmii_m2_r <= rmii_m1_r;
    rmii_m3_r <= rmii_m2_r;
    if (addr_m2_r == addr_m3_r) begin
      addr_s2_r <= addr_m3_r;
    end
    if (mode_m2_r == mode_m3_r) begin
      mode_s2_r <= mode_m3_r;
    end
    if (rmii_m2_r == rmii_m3_r) begin
      rmii_s2_r <= rmii_m3_r;
    end
  end

  assign in_reset = sys_rst | pin_rst_r;
  assign settled = (settle_r == 3'(pscl_pkg::SETTLE_CYCLES - 1));
  assign capture = (state_r == pscl_pkg::PSCL_S_SETTLE) & settled;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pscl_pkg::PSCL_S_RESET: state_nxt = pscl_pkg::PSCL_S_SETTLE;
      pscl_pkg::PSCL_S_SETTLE: begin
        if (settled) begin
          state_nxt = pscl_pkg::PSCL_S_RUN;
        end
      end
      pscl_pkg::PSCL_S_RUN: state_nxt = pscl_pkg::PSCL_S_RUN;
      default: state_nxt = pscl_pkg::PSCL_S_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (in_reset) begin
      state_r <= pscl_pkg::PSCL_S_RESET;
      settle_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == pscl_pkg::PSCL_S_SETTLE) begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

  // Bus decode, 16-bit registers in the low half of each word
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & (state_r == pscl_pkg::PSCL_S_RUN);
  assign wdat = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                 wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  assign soft_rst_wr = bus_wr & (wb_adr_i == pscl_pkg::ADDR_CTRL) &
                       wb_sel_i[1] & wb_dat_i[pscl_pkg::CTRL_SOFT_RST];
  assign mapped = (wb_adr_i == pscl_pkg::ADDR_CTRL) |
                  (wb_adr_i == pscl_pkg::ADDR_ADV) |
                  (wb_adr_i == pscl_pkg::ADDR_MODES) |
                  (wb_adr_i == pscl_pkg::ADDR_STAT);
  assign mode_now = modes_r[pscl_pkg::MODES_MODE_LSB +: 3];

  // Defaults for control bits 13,12,11,8 from a mode value
  function automatic logic [15:0] mode_ctrl(input logic [2:0] m);
    logic [15:0] c;
    c = 16'h0000;
    unique case (pscl_pkg::pscl_mode_e'(m))
      pscl_pkg::PSCL_M_10H: c = 16'h0000;
      pscl_pkg::PSCL_M_10F: c[pscl_pkg::CTRL_DUPLEX] = 1'b1;
      pscl_pkg::PSCL_M_100H: c[pscl_pkg::CTRL_SPEED] = 1'b1;
      pscl_pkg::PSCL_M_100F: begin
        c[pscl_pkg::CTRL_SPEED] = 1'b1;
        c[pscl_pkg::CTRL_DUPLEX] = 1'b1;
      end
      pscl_pkg::PSCL_M_AN100H, pscl_pkg::PSCL_M_REPEAT: begin
        c[pscl_pkg::CTRL_SPEED] = 1'b1;
        c[pscl_pkg::CTRL_ANEG] = 1'b1;
      end
      pscl_pkg::PSCL_M_PDOWN: c[pscl_pkg::CTRL_PDOWN] = 1'b1;
      pscl_pkg::PSCL_M_ALL: begin
        // Don't-care speed and duplex resolved to the fastest
        c[pscl_pkg::CTRL_SPEED] = 1'b1;
        c[pscl_pkg::CTRL_ANEG] = 1'b1;
        c[pscl_pkg::CTRL_DUPLEX] = 1'b1;
      end
    endcase
    return c;
  endfunction

  function automatic logic [3:0] mode_adv(input logic [2:0] m,
                                          input logic [3:0] keep);
    logic [3:0] a;
    a = keep;
    if (m == pscl_pkg::PSCL_M_AN100H || m == pscl_pkg::PSCL_M_REPEAT) begin
      a = pscl_pkg::ADV_HALF100;
    end else if (m == pscl_pkg::PSCL_M_ALL) begin
      a = pscl_pkg::ADV_ALL;
    end
    return a;
  endfunction

  always_ff @(posedge clk) begin
    if (in_reset) begin
      ctrl_r <= 16'h0000;
      adv_r <= pscl_pkg::ADV_RESET;
      modes_r <= 16'h0000;
      crs_tx_r <= 1'b1;
      repeat_r <= 1'b0;
    end else if (capture) begin
      modes_r <= 16'h0000;
      modes_r[pscl_pkg::MODES_ADDR_LSB +: 3] <= addr_s2_r;
      modes_r[pscl_pkg::MODES_MODE_LSB +: 3] <= mode_s2_r;
      modes_r[pscl_pkg::MODES_IFKIND] <= rmii_s2_r;
      ctrl_r <= mode_ctrl(mode_s2_r);
      adv_r[pscl_pkg::ADV_LSB +: 4] <=
        mode_adv(mode_s2_r, adv_r[pscl_pkg::ADV_LSB +: 4]);
      crs_tx_r <= ~mode_s2_r[0] | (mode_s2_r == pscl_pkg::PSCL_M_ALL);
      repeat_r <= (mode_s2_r == pscl_pkg::PSCL_M_REPEAT);
    end else if (soft_rst_wr) begin
      // Soft reset rebuilds from the mode field, never from straps
      ctrl_r <= mode_ctrl(mode_now);
      adv_r[pscl_pkg::ADV_LSB +: 4] <=
        mode_adv(mode_now, adv_r[pscl_pkg::ADV_LSB +: 4]);
      crs_tx_r <= ~mode_now[0] | (mode_now == pscl_pkg::PSCL_M_ALL);
      repeat_r <= (mode_now == pscl_pkg::PSCL_M_REPEAT);
    end else if (bus_wr) begin
      // Software overrides; otherwise values hold
      if (wb_adr_i == pscl_pkg::ADDR_CTRL) begin
        ctrl_r <= wdat & 16'h7FFF;
      end
      if (wb_adr_i == pscl_pkg::ADDR_ADV) begin
        adv_r <= wdat;
      end
      if (wb_adr_i == pscl_pkg::ADDR_MODES) begin
        modes_r <= wdat;
        // Interface kind is fixed at capture; writes leave it
        modes_r[pscl_pkg::MODES_IFKIND] <= modes_r[pscl_pkg::MODES_IFKIND];
      end
    end
  end

  always_comb begin
    rdat = 16'h0000;
    if (wb_adr_i == pscl_pkg::ADDR_CTRL) begin
      rdat = ctrl_r;
    end else if (wb_adr_i == pscl_pkg::ADDR_ADV) begin
      rdat = adv_r;
    end else if (wb_adr_i == pscl_pkg::ADDR_MODES) begin
      rdat = modes_r;
    end else if (wb_adr_i == pscl_pkg::ADDR_STAT) begin
      rdat = {12'h000, repeat_r, crs_tx_r, state_r};
    end
  end

  // One-wait-state slave; unmapped reads return zero, writes dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & mapped) ? {16'h0000, rdat} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (in_reset) begin
      frame_match <= 1'b0;
      scrambler_seed <= 11'h000;
      shared_pins_oe <= 1'b0;
      host_if_rmii <= 1'b0;
      core_powered_down <= 1'b0;
      carrier_on_transmit <= 1'b0;
      repeater_mode <= 1'b0;
      core_reconfig <= 1'b0;
    end else begin
      frame_match <= frame_valid & (state_r == pscl_pkg::PSCL_S_RUN) &
        (frame_address == modes_r[pscl_pkg::MODES_ADDR_LSB +: 5]);
      scrambler_seed <= 11'(modes_r[pscl_pkg::MODES_ADDR_LSB +: 5]);
      shared_pins_oe <= (state_r == pscl_pkg::PSCL_S_RUN);
      host_if_rmii <= modes_r[pscl_pkg::MODES_IFKIND];
      core_powered_down <= ctrl_r[pscl_pkg::CTRL_PDOWN];
      carrier_on_transmit <= crs_tx_r;
      repeater_mode <= repeat_r;
      core_reconfig <= capture | soft_rst_wr;
    end
  end

  property p_pins_quiet;
    @(posedge clk) disable iff (sys_rst)
      (state_r != pscl_pkg::PSCL_S_RUN) |=> !shared_pins_oe;
  endproperty
  a_pins_quiet: assert property (p_pins_quiet) else $error("pins on");

  property p_addr_cap;
    @(posedge clk) disable iff (in_reset)
      capture |=> modes_r[2:0] == $past(addr_s2_r);
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("addr lost");

  property p_if_kind;
    @(posedge clk) disable iff (in_reset)
      capture |=> ##1 host_if_rmii == $past(rmii_s2_r, 2);
  endproperty
  a_if_kind: assert property (p_if_kind) else $error("if kind wrong");

  property p_match;
    @(posedge clk) disable iff (in_reset)
      frame_match |-> $past(frame_address) == $past(modes_r[4:0]);
  endproperty
  a_match: assert property (p_match) else $error("bad match");

  property p_pdown;
    @(posedge clk) disable iff (in_reset)
      capture && mode_s2_r == pscl_pkg::PSCL_M_PDOWN |=> ##1 core_powered_down;
  endproperty
  a_pdown: assert property (p_pdown) else $error("no power down");

  property p_soft_keep;
    @(posedge clk) disable iff (in_reset)
      soft_rst_wr |=> modes_r == $past(modes_r);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("reread");

  property p_all_adv;
    @(posedge clk) disable iff (in_reset)
      capture && mode_s2_r == pscl_pkg::PSCL_M_ALL |=> adv_r[8:5] == 4'hF;
  endproperty
  a_all_adv: assert property (p_all_adv) else $error("adv wrong");

  property p_hold;
    @(posedge clk) disable iff (in_reset)
      state_r == pscl_pkg::PSCL_S_RUN && !bus_wr |=> $stable(modes_r);
  endproperty
  a_hold: assert property (p_hold) else $error("capture drifted");

  // Capture or soft reset must give exactly one reconfigure pulse
  sequence s_cfg_event;
    capture || soft_rst_wr;
  endsequence
  sequence s_reconf_pulse;
    core_reconfig ##1 !core_reconfig;
  endsequence
  property p_reconf;
    @(posedge clk) disable iff (in_reset)
      s_cfg_event |=> s_reconf_pulse;
  endproperty
  a_reconf: assert property (p_reconf) else $error("no reconfig");
endmodule
`default_nettype wire

// *** core/pscl_pkg.sv ***
// Constants and register map of the strap configuration loader
//
// Overview of operation
// - Latch three address straps at reset end
// - Answer only management frames with matching address
// - Station address seeds the transmit scrambler
// - Straps give 0-7; software writes larger address
// - Reset release loads control bits from mode straps
// - Soft reset keeps modes register, ignores straps
// - Modes 000/001: 10 Mb/s half/full, no autoneg
// - Mode 010: 100 half, carrier on both
// - Mode 011: 100 full, carrier on receive
// - Mode 100: autoneg advertising 100 half only
// - Mode 101: repeater, like 100, receive carrier
// - Mode 110: powered down until mode rewrite and soft reset
// - Mode 111: autoneg advertising every ability
// - Reduced-interface strap sampled at reset release
// - Strap low selects MII, high selects RMII
// - Interface kind bit loaded from strap, reported
// - Straps latched on power-on and pin reset
package pscl_pkg;
  // Register byte addresses on the bus
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ADV = 4'h4;
  localparam logic [3:0] ADDR_MODES = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  // Control register field positions
  localparam int CTRL_SOFT_RST = 15;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_ANEG = 12;
  localparam int CTRL_PDOWN = 11;
  localparam int CTRL_DUPLEX = 8;
  // Special modes register fields
  localparam int MODES_ADDR_LSB = 0;
  localparam int MODES_MODE_LSB = 5;
  localparam int MODES_IFKIND = 14;
  // Advertisement bits 8:5
  localparam int ADV_LSB = 5;
  localparam logic [3:0] ADV_HALF100 = 4'h4;
  localparam logic [3:0] ADV_ALL = 4'hF;
  localparam logic [15:0] ADV_RESET = 16'h0001;
  // Straps settle after reset release for this many cycles
  localparam int SETTLE_CYCLES = 4;
  typedef enum logic [2:0] {
    PSCL_M_10H = 3'b000,
    PSCL_M_10F = 3'b001,
    PSCL_M_100H = 3'b010,
    PSCL_M_100F = 3'b011,
    PSCL_M_AN100H = 3'b100,
    PSCL_M_REPEAT = 3'b101,
    PSCL_M_PDOWN = 3'b110,
    PSCL_M_ALL = 3'b111
  } pscl_mode_e;
  typedef enum logic [1:0] {
    PSCL_S_RESET = 2'b00,
    PSCL_S_SETTLE = 2'b01,
    PSCL_S_RUN = 2'b10
  } pscl_state_e;
endpackage

// *** tb/pscl_mgmt_model.sv ***
// Management controller model: bus master and frame source
`timescale 1ns/1ps
`default_nettype none
module pscl_mgmt_model (
  input wire logic clk,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic frame_match,
  output logic [3:0] wb_adr_i,
  output logic [31:0] wb_dat_i,
  output logic [3:0] wb_sel_i,
  output logic wb_we_i,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic [4:0] frame_address,
  output logic frame_valid
);
  initial begin
    {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    {wb_we_i, wb_cyc_i, wb_stb_i} = '0;
    frame_address = 5'h00;
    frame_valid = 1'b0;
  end
  // Overrides of strap defaults go through here
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [15:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'h3;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  // Match is a pulse, so it is looked at in its one cycle
  task automatic frame(input logic [4:0] a, output logic m);
    @(posedge clk);
    frame_address <= a;
    frame_valid <= 1'b1;
    @(posedge clk);
    frame_valid <= 1'b0;
    @(posedge clk);
    m = frame_match;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the strap configuration loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    n_fail++; \
    $display("Error at %0t: got %h, expected %h", $time, a, b); \
  end \
end
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hardware_reset_pin_n = 1'b1;
  logic [2:0] station_address_straps = 3'h0;
  logic [2:0] mode_straps = 3'h0;
  logic reduced_if_select_strap = 1'b0;
  logic [3:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0] sel;
  logic we, cyc, stb, ack, fvalid, fmatch, oe, rmii, pdown, cot, rep;
  logic reconf;
  int n_reconf = 0;
  int k0;
  logic [31:0] exp_modes;
  logic [4:0] faddr;
  logic [10:0] seed;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] d;
  logic m;
  logic [15:0] ctrl_x [8] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100,
                               16'h3000, 16'h3000, 16'h0800, 16'h3100};
  logic [15:0] adv_x [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0080, 16'h0080, 16'h0000, 16'h01E0};
  logic [7:0] cot_x = 8'hD5;
  logic [7:0] rep_x = 8'h20;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (reconf === 1'b1) begin
      n_reconf++;
    end
  end
  pscl_loader DUT (.clk(clk), .sys_rst(sys_rst),
    .hardware_reset_pin_n(hardware_reset_pin_n),
    .station_address_straps(station_address_straps),
    .mode_straps(mode_straps),
    .reduced_if_select_strap(reduced_if_select_strap),
    .frame_address(faddr), .frame_valid(fvalid), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frame_match(fmatch), .scrambler_seed(seed), .shared_pins_oe(oe),
    .host_if_rmii(rmii), .core_powered_down(pdown),
    .carrier_on_transmit(cot), .repeater_mode(rep), .core_reconfig(reconf));
  pscl_mgmt_model MGMT (.clk(clk), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frame_match(fmatch), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .frame_address(faddr), .frame_valid(fvalid));
  task automatic wait_run;
    for (int k = 0; k < 40 && oe !== 1'b1; k++) @(posedge clk);
    `CHK(oe, 1'b1)
  endtask
  task automatic pin_reset(input logic [2:0] a, input logic [2:0] md,
                           input logic r);
    @(posedge clk);
    hardware_reset_pin_n <= 1'b0;
    station_address_straps <= a;
    mode_straps <= md;
    reduced_if_select_strap <= r;
    repeat (8) @(posedge clk);
    `CHK(oe, 1'b0)
    hardware_reset_pin_n <= 1'b1;
    wait_run();
  endtask
  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    wait_run();
    MGMT.xfer(1'b0, pscl_pkg::ADDR_MODES, 16'h0000, d);
    `CHK(d & 32'h0000_40FF, 32'h0000_0000)
    $display("Test power_on done");
    for (int i = 0; i < 8; i++) begin
      pin_reset(3'(i), 3'(i), i[0]);
      MGMT.xfer(1'b0, pscl_pkg::ADDR_CTRL, 16'h0000, d);
      d = d & {16'h0000, (i == 6) ? 16'h0800 : 16'h3900};
      `CHK(d[15:8], ctrl_x[i][15:8])
      `CHK(d, {16'h0000, ctrl_x[i]})
      if (i != 6) begin
        MGMT.xfer(1'b0, pscl_pkg::ADDR_ADV, 16'h0000, d);
        `CHK(d & 32'h0000_01E0, {16'h0000, adv_x[i]})
      end
      `CHK(pdown, 1'(i == 6))
      `CHK(cot, cot_x[i])
      `CHK(rep, rep_x[i])
      MGMT.xfer(1'b0, pscl_pkg::ADDR_MODES, 16'h0000, d);
      exp_modes = {16'h0000, 1'b0, i[0], 6'h00, 3'(i), 2'b00, 3'(i)};
      `CHK(d & 32'h0000_40FF, exp_modes)
      `CHK(rmii, i[0])
      `CHK(seed, {8'h00, 3'(i)})
      MGMT.frame({2'b00, 3'(i)}, m);
      `CHK(m, 1'b1)
      MGMT.frame(5'h18, m);
      `CHK(m, 1'b0)
      $display("Test mode %0d done", i);
    end
    // Straps move after capture; registers must ignore them
    pin_reset(3'h2, 3'h6, 1'b1);
    mode_straps <= 3'h0;
    reduced_if_select_strap <= 1'b0;
    MGMT.xfer(1'b1, pscl_pkg::ADDR_MODES, 16'h0075, d);
    k0 = n_reconf;
    MGMT.xfer(1'b1, pscl_pkg::ADDR_CTRL, 16'h8000, d);
    repeat (4) @(posedge clk);
    `CHK(n_reconf - k0, 1)
    MGMT.xfer(1'b0, pscl_pkg::ADDR_CTRL, 16'h0000, d);
    `CHK(d & 32'h0000_3900, 32'h0000_2100)
    `CHK(pdown, 1'b0)
    MGMT.xfer(1'b0, pscl_pkg::ADDR_MODES, 16'h0000, d);
    `CHK(d & 32'h0000_40FF, 32'h0000_4075)
    `CHK(rmii, 1'b1)
    `CHK(seed, 11'h015)
    MGMT.frame(5'h15, m);
    `CHK(m, 1'b1)
    MGMT.xfer(1'b0, 4'h2, 16'h0000, d);
    `CHK(d, 32'h0000_0000)
    $display("Test soft_reset done");
    conclude();
  end
endmodule
`default_nettype wire
